/* File: pil_pkg.sv */
// Shared constants and types for the prioritized interrupt latch unit.
// Assumes an 8-bit special-function byte port and a core that runs on the same clock.
package pil_pkg;

  // Source numbering: positions 2..23 carry a request latch
  localparam int LATCH_LO  = 2;
  localparam int LATCH_HI  = 23;
  localparam int NUM_SRC   = 24;
  localparam int MASK_LO   = 4;
  localparam int EXT0_SRC  = 4;
  localparam int CONV_SRC  = 15;
  localparam int TRAP_SRC  = 2;
  localparam int WDOG_SRC  = 3;

  // Code used in the accept record for the shared soft/bad-opcode entry
  localparam logic [4:0] SOFT_CODE = 5'h01;

  // Special-function byte addresses of the latch registers
  localparam logic [7:0] ADDR_UPPER_GROUP = 8'h2E;
  localparam logic [7:0] ADDR_LOW_BYTE    = 8'h3C;
  localparam logic [7:0] ADDR_HIGH_BYTE   = 8'h3D;

  localparam logic [7:0]  LATCH_RESET = 8'h00;
  localparam logic [7:0]  READ_UNMAPPED = 8'h00;

  // Vector addresses
  localparam logic [15:0] VEC_RESET     = 16'hFFFE;
  localparam logic [15:0] VEC_SOFT      = 16'hFFFC;
  localparam logic [15:0] VEC_TRAP      = 16'hFFFA;
  localparam logic [15:0] VEC_WDOG      = 16'hFFF8;
  localparam logic [15:0] VEC_LOW_BASE  = 16'hFFF6;
  localparam logic [15:0] VEC_HIGH_BASE = 16'hFFBE;

  // Acceptance timing: one clock per machine cycle
  localparam int MCYC_PER_ACCEPT = 8;
  localparam int CLK_PER_MCYC    = 1;
  localparam int ACCEPT_CLKS     = MCYC_PER_ACCEPT * CLK_PER_MCYC;

  typedef enum logic [1:0] {
    PIL_IDLE   = 2'b01,
    PIL_ACCEPT = 2'b10
  } pil_state_type;

  typedef struct packed {
    logic [15:0] vector;
    logic [4:0]  src;
    logic        imf_saved;
  } pil_accept_type;

  function automatic logic [15:0] pil_vector_of(input logic [4:0] src);
    logic [15:0] v;
    v = VEC_SOFT;
    if (src == 5'h02) begin
      v = VEC_TRAP;
    end else if (src == 5'h03) begin
      v = VEC_WDOG;
    end else if (src >= 5'h04 && src <= 5'h0F) begin
      v = VEC_LOW_BASE - {10'h000, src - 5'h04, 1'b0};
    end else if (src >= 5'h10) begin
      v = VEC_HIGH_BASE - {10'h000, src - 5'h10, 1'b0};
    end
    return v;
  endfunction : pil_vector_of

endpackage : pil_pkg

/* File: pil_prio_pick.sv */
// Fixed-priority picker: the lowest eligible source position wins.
// Assumes bit n of the input stands for source position n.
`timescale 1ns/100ps
module pil_prio_pick import pil_pkg::*; #(
  parameter int WIDTH = NUM_SRC
) (
  input  wire logic [WIDTH-1:0] eligible,
  output logic                  found,
  output logic [4:0]            pick
);

  // The pick code is five bits wide, so wider inputs cannot be named
  generate
    if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
      $error("WIDTH must be within 1..32");
    end
  endgenerate

  always_comb begin
    found = 1'b0;
    pick  = 5'h00;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        found = 1'b1;
        pick  = 5'(i);
      end
    end
  end

endmodule : pil_prio_pick

/* File: pil_latch_unit.sv */
// Prioritized interrupt latch unit: request latches, enable gating, priority
// pick, acceptance sequence with vector and master-enable handling.
// Assumes request pulses, core strobes and the byte port share clk.
// Operation
// RQ1: Twenty-four sources; trap and watchdog unmaskable, positions 4-23 maskable.
// RQ2: A request sets its latch, which holds and asks the core when enabled.
// RQ3: Maskable needs master and source enable; external 0 also needs pin enable.
// RQ4: Simultaneous requests accepted in fixed order, lowest position first; nesting allowed.
// RQ5: Vectors: trap FFFA, watchdog FFF8, 4-15 from FFF6, 16-23 from FFBE.
// RQ6: Soft trap and bad opcode have no latch and share vector FFFC.
// RQ7: The accepted source's latch clears at acceptance.
// RQ8: Reset forces every latch to zero.
// RQ9: Latches live at bytes 2E, 3C, 3D; writing zero clears a bit.
// RQ10: Writing one never sets a latch; the bit stays unchanged.
// RQ11: Software clears with plain stores, writing ones to trap and watchdog bits.
// RQ12: Software avoids read-modify-write clears, which may lose requests.
// RQ13: Reads of latch bytes return current pending state.
// RQ14: Software drops master enable before altering enables or latches.
// RQ15: Acceptance clears master enable in hardware before the handler runs.
// RQ16: Software clears trap action select to get the trap interrupt.
// RQ17: Software clears watchdog action select to get the watchdog interrupt.
// RQ18: Converter-done latch may clear unserviced while lower-priority acceptance starts.
// RQ19: Unmaskable sources are accepted regardless of enables.
// RQ20: Acceptance lasts eight machine cycles after the current instruction.
// RQ21: A request coinciding with a software clear leaves the latch set.
`timescale 1ns/100ps
module pil_latch_unit import pil_pkg::*; #(
  parameter int ACCEPT_LEN = ACCEPT_CLKS
) (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic [7:0]           sfr_addr,
  input  wire logic                 sfr_wr,
  input  wire logic                 sfr_rd,
  input  wire logic [7:0]           sfr_wdata,
  output logic [7:0]                sfr_rdata,
  input  wire logic [LATCH_HI:0]    req_pulse,
  input  wire logic [LATCH_HI:0]    source_irq_enable,
  input  wire logic                 ext0_pin_enable,
  input  wire logic                 enable_irq_op,
  input  wire logic                 disable_irq_op,
  input  wire logic                 return_op,
  input  wire logic                 return_imf,
  input  wire logic                 soft_trap_irq,
  input  wire logic                 bad_opcode_irq,
  input  wire logic                 insn_done,
  output logic                      irq_request,
  output logic                      master_irq_enable,
  output logic                      accept_busy,
  output logic                      vector_load,
  output pil_accept_type            accept_info,
  output logic [LATCH_HI:0]         request_latch
);

  generate
    if (ACCEPT_LEN < 2 || ACCEPT_LEN > 255) begin : g_bad_len
      $error("ACCEPT_LEN must be within 2..255");
    end
  endgenerate

  pil_state_type      state_ff, nxt_state;
  logic [7:0]         count_ff, nxt_count;
  logic [LATCH_HI:0]  latch_ff, nxt_latch;
  logic               imf_ff, nxt_imf;
  pil_accept_type     info_ff, nxt_info;
  logic [7:0]         rdata_ff, nxt_rdata;
  logic               load_ff, nxt_load;

  logic [LATCH_HI:0]  eligible;
  logic [LATCH_HI:0]  sw_clear;
  logic               found;
  logic [4:0]         pick;
  logic               soft_req;
  logic               accept_start;
  logic               conv_hazard;

  // Per-source eligibility and software-clear decode
  for (genvar i = 0; i <= LATCH_HI; i++) begin : g_src // RQ1
    localparam logic [7:0] BYTE_ADDR = (i < 8)  ? ADDR_LOW_BYTE :
                                       (i < 16) ? ADDR_HIGH_BYTE : ADDR_UPPER_GROUP;
    if (i < LATCH_LO) begin : g_none
      assign eligible[i] = 1'b0; // RQ6
      assign sw_clear[i] = 1'b0;
    end else begin : g_latch
      if (i < MASK_LO) begin : g_nmi
        assign eligible[i] = latch_ff[i]; // RQ19
      end else if (i == EXT0_SRC) begin : g_ext0
        assign eligible[i] = latch_ff[i] & imf_ff & source_irq_enable[i]
                             & ext0_pin_enable; // RQ3
      end else begin : g_mask
        assign eligible[i] = latch_ff[i] & imf_ff & source_irq_enable[i]; // RQ3
      end
      // Only a zero bit clears; a one leaves the latch alone
      assign sw_clear[i] = sfr_wr & (sfr_addr == BYTE_ADDR) & ~sfr_wdata[i % 8]; // RQ9 RQ10
      // Per-latch checks: a request lands unless the converter hazard swallows it, a written one never sets
      a_hw_set_wins: assert property (@(posedge clk) disable iff (!rstn) // RQ2 RQ21
        (req_pulse[i] && !(i == CONV_SRC && conv_hazard)) |=> latch_ff[i])
        else $error("request did not set its latch");
      a_write_keeps: assert property (@(posedge clk) disable iff (!rstn) // RQ10
        (sfr_wr && sfr_addr == BYTE_ADDR && sfr_wdata[i % 8] && !latch_ff[i] && !req_pulse[i])
        |=> !latch_ff[i])
        else $error("software write set a latch bit");
    end
  end

  pil_prio_pick #(
    .WIDTH    (NUM_SRC)
  ) u_pick (
    .eligible (eligible),
    .found    (found),
    .pick     (pick)
  );

  assign soft_req     = soft_trap_irq | bad_opcode_irq;
  assign irq_request  = found | soft_req; // RQ2
  // Acceptance begins only at an instruction boundary; nesting works once the
  // handler sets master enable again, since the sequencer is free by then
  assign accept_start = (state_ff == PIL_IDLE) & insn_done & (found | soft_req); // RQ4 RQ20
  // A converter-done request landing as a lower-priority source starts
  // acceptance is swallowed by the same clear, as the original silicon does
  assign conv_hazard  = accept_start & ~soft_req & found & (pick > 5'(CONV_SRC))
                        & req_pulse[CONV_SRC]; // RQ18

  always_comb begin
    nxt_latch = latch_ff;
    for (int i = LATCH_LO; i <= LATCH_HI; i++) begin
      // Hardware set wins over software and acceptance clears, but not over the converter-done hazard clear
      nxt_latch[i] = req_pulse[i] | (latch_ff[i] & ~sw_clear[i]); // RQ2 RQ21
      if (accept_start && !soft_req && pick == 5'(i) && !req_pulse[i]) begin
        nxt_latch[i] = 1'b0; // RQ7
      end
    end
    if (conv_hazard) begin
      nxt_latch[CONV_SRC] = 1'b0; // RQ18
    end
  end

  always_comb begin
    nxt_imf = imf_ff;
    if (accept_start) begin
      nxt_imf = 1'b0; // RQ15
    end else if (return_op) begin
      nxt_imf = return_imf;
    end else if (enable_irq_op) begin
      nxt_imf = 1'b1;
    end else if (disable_irq_op) begin
      nxt_imf = 1'b0;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_count = count_ff;
    nxt_info  = info_ff;
    nxt_load  = 1'b0;
    case (state_ff)
      PIL_IDLE: begin
        if (accept_start) begin
          nxt_state          = PIL_ACCEPT;
          nxt_count          = 8'(ACCEPT_LEN - 1);
          nxt_info.imf_saved = imf_ff;
          // Soft trap and bad opcode outrank every latched source
          nxt_info.src       = soft_req ? SOFT_CODE : pick; // RQ4 RQ6
          nxt_info.vector    = soft_req ? VEC_SOFT : pil_vector_of(pick); // RQ5 RQ6
        end
      end
      PIL_ACCEPT: begin
        if (count_ff == 8'h00) begin
          nxt_state = PIL_IDLE;
        end else begin
          nxt_count = count_ff - 8'h01;
          nxt_load  = (count_ff == 8'h01); // RQ20
        end
      end
      default: begin
        nxt_state = PIL_IDLE;
      end
    endcase
  end

  always_comb begin
    nxt_rdata = rdata_ff;
    if (sfr_rd) begin
      case (sfr_addr)
        ADDR_LOW_BYTE:    nxt_rdata = {latch_ff[7:LATCH_LO], 2'b00}; // RQ13
        ADDR_HIGH_BYTE:   nxt_rdata = latch_ff[15:8]; // RQ13
        ADDR_UPPER_GROUP: nxt_rdata = latch_ff[23:16]; // RQ13
        default:          nxt_rdata = READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= PIL_IDLE;
      count_ff <= 8'h00;
      latch_ff <= '0; // RQ8
      imf_ff   <= 1'b0;
      info_ff  <= '{vector: VEC_RESET, src: 5'h00, imf_saved: 1'b0};
      rdata_ff <= LATCH_RESET;
      load_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      count_ff <= nxt_count;
      latch_ff <= nxt_latch;
      imf_ff   <= nxt_imf;
      info_ff  <= nxt_info;
      rdata_ff <= nxt_rdata;
      load_ff  <= nxt_load;
    end
  end

  assign sfr_rdata         = rdata_ff;
  assign master_irq_enable = imf_ff;
  assign accept_busy       = (state_ff == PIL_ACCEPT);
  assign vector_load       = load_ff;
  assign accept_info       = info_ff;
  assign request_latch     = latch_ff;

  a_imf_drop_accept: assert property (@(posedge clk) disable iff (!rstn) // RQ15
    accept_start |=> !imf_ff [*1] ##0 accept_busy)
    else $error("master enable not cleared on acceptance");

  a_latch_clear_accept: assert property (@(posedge clk) disable iff (!rstn) // RQ7
    (accept_start && !soft_req && pick == 5'h09 && !req_pulse[9]) |=> !latch_ff[9])
    else $error("accepted latch not cleared");

  a_write_no_set: assert property (@(posedge clk) disable iff (!rstn) // RQ10
    (sfr_wr && sfr_addr == ADDR_LOW_BYTE && sfr_wdata[3] && !latch_ff[3] && !req_pulse[3])
    |=> !latch_ff[3])
    else $error("software write set a latch");

  a_set_beats_clear: assert property (@(posedge clk) disable iff (!rstn) // RQ21
    (req_pulse[20] && sfr_wr && sfr_addr == ADDR_UPPER_GROUP && !sfr_wdata[4]) |=> latch_ff[20])
    else $error("request lost against software clear");

  a_mask_gating: assert property (@(posedge clk) disable iff (!rstn) // RQ3
    (accept_start && !soft_req) |-> (pick < 5'h04 || (imf_ff && source_irq_enable[pick])))
    else $error("maskable source accepted while disabled");

  a_accept_length: assert property (@(posedge clk) disable iff (!rstn) // RQ20
    accept_start |=> accept_busy [*8] ##1 !accept_busy)
    else $error("acceptance did not last eight cycles");

  a_vector_load_time: assert property (@(posedge clk) disable iff (!rstn) // RQ20
    accept_start |-> ##7 (!vector_load) ##1 vector_load)
    else $error("vector load not at end of acceptance");

  a_vector_ext0: assert property (@(posedge clk) disable iff (!rstn) // RQ5
    (accept_start && !soft_req && pick == 5'h04) |=> accept_info.vector == 16'hFFF6)
    else $error("wrong vector for external input 0");

  a_vector_soft: assert property (@(posedge clk) disable iff (!rstn) // RQ6
    (accept_start && soft_req) |=> accept_info.vector == 16'hFFFC)
    else $error("wrong vector for soft trap");

  a_read_status: assert property (@(posedge clk) disable iff (!rstn) // RQ13
    (sfr_rd && sfr_addr == ADDR_UPPER_GROUP) |=> sfr_rdata == $past(latch_ff[23:16]))
    else $error("latch read does not match state");

  a_conv_hazard: assert property (@(posedge clk) disable iff (!rstn) // RQ18
    (accept_start && !soft_req && found && pick > 5'h0F && req_pulse[15])
    |=> !latch_ff[15])
    else $error("converter hazard not reproduced");

  a_nmi_taken: assert property (@(posedge clk) disable iff (!rstn) // RQ19
    (!accept_busy && insn_done && (latch_ff[TRAP_SRC] || latch_ff[WDOG_SRC])) |=> accept_busy)
    else $error("unmaskable source not accepted");

  a_lowest_first: assert property (@(posedge clk) disable iff (!rstn) // RQ4
    (accept_start && !soft_req)
    |-> (eligible & ((24'h000001 << pick) - 24'h000001)) == 24'h000000)
    else $error("higher-priority source passed over");

  a_ext0_pin: assert property (@(posedge clk) disable iff (!rstn) // RQ3
    (accept_start && !soft_req && pick == 5'h04) |-> ext0_pin_enable)
    else $error("external input 0 accepted with its pin disabled");

  a_soft_outranks: assert property (@(posedge clk) disable iff (!rstn) // RQ4 RQ6
    (accept_start && soft_req) |=> accept_info.src == SOFT_CODE)
    else $error("soft trap did not outrank latched sources");

  a_vector_trap: assert property (@(posedge clk) disable iff (!rstn) // RQ5
    (accept_start && !soft_req && pick == 5'h02) |=> accept_info.vector == 16'hFFFA)
    else $error("wrong vector for the fetch trap");

  a_vector_last: assert property (@(posedge clk) disable iff (!rstn) // RQ5
    (accept_start && !soft_req && pick == 5'h17) |=> accept_info.vector == 16'hFFB0)
    else $error("wrong vector for the last source");

  a_read_low: assert property (@(posedge clk) disable iff (!rstn) // RQ13
    (sfr_rd && sfr_addr == ADDR_LOW_BYTE) |=> sfr_rdata == {$past(latch_ff[7:2]), 2'b00})
    else $error("low latch byte read does not match state");

  a_rdata_holds: assert property (@(posedge clk) disable iff (!rstn) // RQ13
    !sfr_rd |=> $stable(sfr_rdata))
    else $error("read data changed without a read");

  a_load_in_busy: assert property (@(posedge clk) disable iff (!rstn) // RQ20
    vector_load |-> accept_busy)
    else $error("vector load outside acceptance");

endmodule : pil_latch_unit

/* File: pil_core_model.sv */
// Core-side model: ends instructions on command, raises soft traps, returns.
// Assumes it shares clk and rstn with the latch unit.
`timescale 1ns/100ps
module pil_core_model import pil_pkg::*; (
  input  wire logic           clk,
  input  wire logic           rstn,
  input  wire logic           step,
  input  wire logic           slow,
  input  wire logic           ret_en,
  input  wire logic [1:0]     soft_sel,
  input  wire logic           vector_load,
  input  wire pil_accept_type accept_info,
  output logic                insn_done,
  output logic                soft_trap_irq,
  output logic                bad_opcode_irq,
  output logic                return_op,
  output logic                return_imf
);
  logic [3:0] sh_ff;
  // Slow mode lengthens the instruction; acceptance must wait for its end
  assign insn_done      = slow ? sh_ff[3] : sh_ff[0];
  assign soft_trap_irq  = insn_done & soft_sel[0];
  assign bad_opcode_irq = insn_done & soft_sel[1];
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sh_ff      <= 4'h0;
      return_op  <= 1'b0;
      return_imf <= 1'b0;
    end else begin
      sh_ff      <= {sh_ff[2:0], step};
      // Quick return so the stacked enable is back before the next step
      return_op  <= ret_en & vector_load;
      return_imf <= accept_info.imf_saved;
    end
  end
endmodule : pil_core_model

/* File: pil_latch_unit_tb_top.sv */
// Self-checking bench for the interrupt latch unit beside a core-side model.
// Assumes one 10 MHz clock and the default acceptance length.
`timescale 1ns/100ps
module pil_latch_unit_tb_top import pil_pkg::*;;
  typedef struct packed {logic [4:0] src; logic [15:0] vec;} pil_row_type;
  logic           clk, rstn, sfr_wr, sfr_rd, ext0_pin_enable, step, slow, ret_en;
  logic           enable_irq_op, disable_irq_op, irq_request, master_irq_enable;
  logic           accept_busy, vector_load, insn_done, soft_trap_irq, bad_opcode_irq;
  logic           return_op, return_imf;
  logic [1:0]     soft_sel;
  logic [7:0]     sfr_addr, sfr_wdata, sfr_rdata;
  logic [23:0]    req_pulse, source_irq_enable, request_latch;
  pil_accept_type accept_info;
  int             bad_count, check_count;
  pil_row_type    rows [7] = '{'{5'h02, 16'hFFFA}, '{5'h03, 16'hFFF8}, '{5'h04, 16'hFFF6},
    '{5'h09, 16'hFFEC}, '{5'h0F, 16'hFFE0}, '{5'h10, 16'hFFBE}, '{5'h17, 16'hFFB0}};
  logic [15:0]    rdv [4] = '{16'h3C04, 16'h3D20, 16'h2E10, 16'h4000};

  pil_latch_unit #(.ACCEPT_LEN(ACCEPT_CLKS)) uut (.clk(clk), .rstn(rstn),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .req_pulse(req_pulse), .source_irq_enable(source_irq_enable),
    .ext0_pin_enable(ext0_pin_enable), .enable_irq_op(enable_irq_op),
    .disable_irq_op(disable_irq_op), .return_op(return_op), .return_imf(return_imf),
    .soft_trap_irq(soft_trap_irq), .bad_opcode_irq(bad_opcode_irq), .insn_done(insn_done),
    .irq_request(irq_request), .master_irq_enable(master_irq_enable),
    .accept_busy(accept_busy), .vector_load(vector_load), .accept_info(accept_info),
    .request_latch(request_latch));
  pil_core_model core (.clk(clk), .rstn(rstn), .step(step), .slow(slow), .ret_en(ret_en),
    .soft_sel(soft_sel), .vector_load(vector_load), .accept_info(accept_info),
    .insn_done(insn_done), .soft_trap_irq(soft_trap_irq), .bad_opcode_irq(bad_opcode_irq),
    .return_op(return_op), .return_imf(return_imf));

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic ctl(input logic en);
    @(posedge clk);
    enable_irq_op  <= en;
    disable_irq_op <= ~en;
    @(posedge clk);
    enable_irq_op  <= 1'b0;
    disable_irq_op <= 1'b0;
  endtask : ctl
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [23:0] m);
    @(posedge clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    req_pulse <= m;
    @(posedge clk);
    sfr_wr    <= 1'b0;
    req_pulse <= 24'h000000;
  endtask : wr
  task automatic req(input logic [23:0] m);
    @(posedge clk);
    req_pulse <= m;
    @(posedge clk);
    req_pulse <= 24'h000000;
  endtask : req
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    @(negedge clk);
    chk({16'h0000, sfr_rdata}, {16'h0000, e});
  endtask : rd
  // Runs one instruction end and follows the acceptance it should start
  task automatic acc(input logic [4:0] s, input logic [15:0] v);
    int k;
    int n;
    int vl;
    k = 0;
    n = 0;
    vl = 0;
    @(posedge clk);
    step <= 1'b1;
    @(posedge clk);
    step <= 1'b0;
    while (accept_busy !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    if (k == 20) begin
      bad_count++;
      $display("ERROR %0t no acceptance", $time);
      end_of_test();
    end
    chk({8'h00, accept_info.vector}, {8'h00, v});
    chk({19'h0, accept_info.src}, {19'h0, s});
    chk_bit(master_irq_enable, 1'b0);
    chk_bit(request_latch[s], 1'b0);
    while (accept_busy === 1'b1 && n < 20) begin
      n++;
      if (vector_load === 1'b1) vl = n;
      @(negedge clk);
    end
    chk_bit(n == ACCEPT_CLKS, 1'b1);
    chk_bit(vl == ACCEPT_CLKS, 1'b1);
  endtask : acc

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    {rstn, sfr_wr, sfr_rd, step, slow, ret_en, enable_irq_op, disable_irq_op} = 8'h00;
    {sfr_addr, sfr_wdata, soft_sel, req_pulse} = 42'h0;
    source_irq_enable = 24'hFFFFF0;
    ext0_pin_enable = 1'b1;
    bad_count = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk(request_latch, 24'h000000);
    chk({8'h00, accept_info.vector}, {8'h00, 16'hFFFE});
    chk_bit(master_irq_enable | accept_busy | irq_request, 1'b0);
    foreach (rows[i]) begin
      ctl(1'b1);
      req(24'h000001 << rows[i].src);
      @(negedge clk);
      chk_bit(irq_request, 1'b1);
      rd(rows[i].src[4] ? 8'h2E : (rows[i].src[3] ? 8'h3D : 8'h3C),
         8'h01 << rows[i].src[2:0]);
      acc(rows[i].src, rows[i].vec);
    end
    @(posedge clk);
    ret_en <= 1'b1;
    ctl(1'b1);
    req(24'h800220);
    acc(5'h05, 16'hFFF4);
    acc(5'h09, 16'hFFEC);
    acc(5'h17, 16'hFFB0);
    @(negedge clk);
    chk_bit(master_irq_enable, 1'b1);
    @(posedge clk);
    ret_en <= 1'b0;
    ctl(1'b0);
    req(24'h000030);
    @(negedge clk);
    chk_bit(irq_request, 1'b0);
    @(posedge clk);
    source_irq_enable <= 24'hFFFFD0;
    ext0_pin_enable <= 1'b0;
    ctl(1'b1);
    @(negedge clk);
    chk_bit(irq_request, 1'b0);
    @(posedge clk);
    ext0_pin_enable <= 1'b1;
    @(negedge clk);
    chk_bit(irq_request, 1'b1);
    acc(5'h04, 16'hFFF6);
    @(posedge clk);
    slow <= 1'b1;
    // Trap taken as an interrupt in slow mode, trap action select assumed cleared
    req(24'h000004);
    acc(5'h02, 16'hFFFA);
    @(posedge clk);
    slow <= 1'b0;
    ctl(1'b1);
    req(24'h010000);
    @(posedge clk);
    step <= 1'b1;
    @(posedge clk);
    step <= 1'b0;
    req_pulse <= 24'h008000;
    @(posedge clk);
    req_pulse <= 24'h000000;
    @(negedge clk);
    chk_bit(request_latch[15], 1'b0);
    repeat (10) @(negedge clk);
    req(24'h800000);
    for (int j = 1; j < 3; j++) begin
      ctl(1'b1);
      @(posedge clk);
      soft_sel <= j[1:0];
      acc(5'h01, 16'hFFFC);
      chk_bit(request_latch[23], 1'b1);
    end
    @(posedge clk);
    soft_sel <= 2'b00;
    ctl(1'b0);
    req(24'h003004);
    wr(8'h3C, 8'h0C, 24'h000000);
    wr(8'h3D, 8'hEF, 24'h000000);
    wr(8'h2E, 8'h00, 24'h100000);
    wr(8'h3D, 8'hFF, 24'h000000);
    @(negedge clk);
    chk(request_latch, 24'h102004);
    foreach (rdv[i]) rd(rdv[i][15:8], rdv[i][7:0]);
    @(posedge clk);
    rstn <= 1'b0;
    @(negedge clk);
    chk(request_latch, 24'h000000);
    @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    end_of_test();
  end
endmodule : pil_latch_unit_tb_top
